// [dcp_pkg.sv]
// divider channel phase control: shared types and constants
// assumes one 200 MHz clock domain (sys_clk) for the whole block
package dcp_pkg;
    localparam int          DCP_NCH      = 14;       // output channels
    localparam logic [3:0]  DCP_LAUNCH_CYC = 4'h4;   // input cycles from start phase to stream
    localparam logic [11:0] DCP_SLIP_ONE = 12'h001;  // single slip amount
    localparam logic [1:0]  DCP_ASYNC    = 2'h0;     // launch behaviour codes
    localparam logic [1:0]  DCP_DYNAMIC  = 2'h3;
    localparam logic [1:0]  DCP_PIN_NONE = 2'h0;     // pin function codes
    localparam logic [1:0]  DCP_PIN_SLIP = 2'h1;
    localparam logic [1:0]  DCP_PIN_SYNC = 2'h2;
    localparam logic [1:0]  DCP_PIN_PULSE = 2'h3;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        DCP_IDLE   = 5'h01,
        DCP_ENA    = 5'h02,
        DCP_RST    = 5'h04,
        DCP_LAUNCH = 5'h08,
        DCP_RUN    = 5'h10
    } dcp_fsm_e;

    // per-channel configuration
    typedef struct packed {
        logic        enable;
        logic        slip_accept;
        logic        realign_accept;
        logic [1:0]  launch;
        logic        buf_follow;
        logic        idle_low;
        logic        repeat_en;
        logic [11:0] repeat_cnt;
        logic [11:0] divide;
    } dcp_cfg_s;

    // per-channel running state
    typedef struct packed {
        logic [11:0] cnt;
        logic [11:0] slip_left;
        logic        pwr;
        logic        held;
        logic        out;
        logic        buf_en;
        logic        idle_float;
    } dcp_ch_s;

    localparam dcp_ch_s DCP_CH_RST = '0;
endpackage : dcp_pkg

// [dcp_channel_ctrl.sv]
// divider channel phase control: realign, slip, launch and pulse trains
// assumes trigger inputs synchronous to sys_clk; spi requests are one-cycle pulses
//
// Summary of operation
// - slip-accepting channels slip on spi, pin, and repeat-shift auto starts.
// - realign-accepting channels rephase on spi, pin or multi-chip realign events.
// - realign-accept changes sensitivity only, never the running divider.
// - launch 00 starts freely, rephased later only if realign-accept set.
// - launch 11 powers up before train, rephases at start, powers down after.
// - pulse mode buffer enable follows channel enable or divider power.
// - idle pulse channel with buffer on: drive low or float.
// - repeat-shift uses its count and auto starts after realign or train start.
// - with repeat-shift each slip repeats count times, one input cycle each.
// - slips take cycles; alarm raised when all phase work finished.
// - shared 12-bit period timer sequences enable, reset, start, disable.
// - pulse trains last timer periods less the launch cycles, not channel periods.
// - pulse stream starts fixed input cycles after the start phase.
// - stopping a stream forces the output low straight from the sequencer.
// - channel with enable 0 is off whatever else is set.
`timescale 1ns/10ps
`default_nettype none
module dcp_channel_ctrl
    import dcp_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire logic                 soft_restart,
    input  wire logic                 spi_slip_req,
    input  wire logic                 spi_sync_req,
    input  wire logic                 spi_pulse_req,
    input  wire logic                 general_input_pin,
    input  wire logic [1:0]           pin_function,
    input  wire logic                 multi_chip_realign,
    input  wire logic [11:0]          reference_period_count,
    input  wire logic [7:0]           pulse_periods,
    input  wire dcp_cfg_s             chan_cfg [DCP_NCH],
    output logic [DCP_NCH-1:0]        chan_out,
    output logic [DCP_NCH-1:0]        buf_en,
    output logic [DCP_NCH-1:0]        idle_float,
    output logic                      phase_done
);

    typedef struct packed {
        dcp_fsm_e                fsm;
        logic [11:0]             tmr;
        logic [7:0]              periods;
        logic [3:0]              launch_cnt;
        logic                    pend_sync;
        logic                    pend_pulse;
        logic                    is_pulse;
        logic                    pin_q;
        logic                    mcr_q;
        logic                    done;
        dcp_ch_s [DCP_NCH-1:0]   ch;
    } dcp_state_s;

    localparam dcp_state_s ST_RST = '{fsm: DCP_IDLE, ch: '{default: DCP_CH_RST}, default: '0};

    dcp_state_s st_r;
    dcp_state_s st_nxt;

    // channel is live and set for dynamic launch
    function automatic logic is_dyn(input dcp_cfg_s c);
        return c.enable && (c.launch == DCP_DYNAMIC);
    endfunction : is_dyn

    // slip amount: repeat count or a single cycle
    function automatic logic [11:0] slip_amt(input dcp_cfg_s c);
        return c.repeat_en ? c.repeat_cnt : DCP_SLIP_ONE;
    endfunction : slip_amt

    // next state of the whole block
    always_comb begin
        logic tick;
        logic pin_rise;
        logic slip_ev;
        logic sync_ev;
        logic pulse_ev;
        logic rephase;
        logic released;
        logic train_end;
        logic busy;
        logic [11:0] half;
        st_nxt    = st_r;
        tick      = (st_r.tmr >= reference_period_count - 12'h001) || (reference_period_count == 12'h000);
        pin_rise  = general_input_pin && !st_r.pin_q;
        slip_ev   = spi_slip_req || (pin_rise && pin_function == DCP_PIN_SLIP);
        sync_ev   = spi_sync_req || (pin_rise && pin_function == DCP_PIN_SYNC)
                    || (multi_chip_realign && !st_r.mcr_q);
        pulse_ev  = spi_pulse_req || (pin_rise && pin_function == DCP_PIN_PULSE);
        rephase   = 1'b0;
        released  = 1'b0;
        train_end = 1'b0;
        busy      = 1'b0;
        half      = 12'h000;
        st_nxt.pin_q = general_input_pin;
        st_nxt.mcr_q = multi_chip_realign;

        // shared reference period timer
        st_nxt.tmr = tick ? 12'h000 : st_r.tmr + 12'h001;
        st_nxt.pend_sync  = st_r.pend_sync || sync_ev;
        st_nxt.pend_pulse = st_r.pend_pulse || pulse_ev;

        // sequencer, steps on timer ticks; launch counts input cycles
        case (st_r.fsm)
            DCP_IDLE: begin
                if (tick && (st_r.pend_sync || st_r.pend_pulse)) begin
                    st_nxt.is_pulse   = st_r.pend_pulse;
                    st_nxt.pend_sync  = sync_ev;
                    st_nxt.pend_pulse = pulse_ev;
                    st_nxt.fsm        = DCP_ENA;
                end
            end
            DCP_ENA: if (tick) st_nxt.fsm = DCP_RST;
            DCP_RST: begin
                rephase = 1'b1;
                if (tick) begin
                    st_nxt.launch_cnt = DCP_LAUNCH_CYC;
                    st_nxt.fsm        = DCP_LAUNCH;
                end
            end
            DCP_LAUNCH: begin
                rephase = 1'b1;
                st_nxt.launch_cnt = st_r.launch_cnt - 4'h1;
                if (st_r.launch_cnt == 4'h1) begin
                    released       = 1'b1;
                    st_nxt.periods = pulse_periods;
                    st_nxt.fsm     = st_r.is_pulse && pulse_periods != 8'h00 ? DCP_RUN : DCP_IDLE;
                    train_end      = !(st_r.is_pulse && pulse_periods != 8'h00);
                end
            end
            DCP_RUN: begin
                if (tick) begin
                    st_nxt.periods = st_r.periods - 8'h01;
                    if (st_r.periods == 8'h01) begin
                        st_nxt.fsm = DCP_IDLE;
                        train_end  = 1'b1;
                    end
                end
            end
            default: st_nxt.fsm = DCP_IDLE;
        endcase

        // per-channel divider, slip and output control
        for (int i = 0; i < DCP_NCH; i++) begin
            half = chan_cfg[i].divide >> 1;
            // divider power: async follows enable, dynamic follows trains
            if (!chan_cfg[i].enable) begin
                st_nxt.ch[i].pwr = 1'b0;
            end else if (!is_dyn(chan_cfg[i])) begin
                st_nxt.ch[i].pwr = 1'b1;
            end else if (st_r.fsm == DCP_ENA && st_r.is_pulse) begin
                st_nxt.ch[i].pwr = 1'b1;
            end else if (train_end && st_r.is_pulse) begin
                st_nxt.ch[i].pwr = 1'b0;
            end
            // phase reset held from reset phase to launch release
            if (rephase && (chan_cfg[i].realign_accept || (is_dyn(chan_cfg[i]) && st_r.is_pulse))) begin
                st_nxt.ch[i].held = 1'b1;
            end
            if (released) begin
                st_nxt.ch[i].held = 1'b0;
            end
            // slip loading: broadcast, or auto after realign or train start
            if (chan_cfg[i].enable && chan_cfg[i].slip_accept) begin
                if (slip_ev) begin
                    st_nxt.ch[i].slip_left = slip_amt(chan_cfg[i]);
                end else if (released && st_r.ch[i].held && chan_cfg[i].repeat_en) begin
                    st_nxt.ch[i].slip_left = chan_cfg[i].repeat_cnt;
                end
            end
            // divider count
            if (!chan_cfg[i].enable || !st_r.ch[i].pwr || st_r.ch[i].held) begin
                st_nxt.ch[i].cnt = 12'h000;
            end else if (st_r.ch[i].slip_left != 12'h000 && !slip_ev) begin
                st_nxt.ch[i].slip_left = st_r.ch[i].slip_left - 12'h001;
                st_nxt.ch[i].cnt       = st_r.ch[i].cnt;
            end else if (st_r.ch[i].cnt >= chan_cfg[i].divide - 12'h001) begin
                st_nxt.ch[i].cnt = 12'h000;
            end else begin
                st_nxt.ch[i].cnt = st_r.ch[i].cnt + 12'h001;
            end
            // output: high half of the period; dynamic gated by sequencer
            st_nxt.ch[i].out = chan_cfg[i].enable && st_r.ch[i].pwr && !st_r.ch[i].held
                               && (st_r.ch[i].cnt < half)
                               && !(is_dyn(chan_cfg[i]) && st_nxt.fsm != DCP_RUN);
            // buffer enable
            st_nxt.ch[i].buf_en = chan_cfg[i].enable
                                  && !(is_dyn(chan_cfg[i]) && chan_cfg[i].buf_follow
                                       && !st_nxt.ch[i].pwr);
            // idle level outside trains
            st_nxt.ch[i].idle_float = is_dyn(chan_cfg[i]) && st_nxt.ch[i].buf_en
                                      && st_nxt.fsm != DCP_RUN && !chan_cfg[i].idle_low;
            if (st_nxt.ch[i].slip_left != 12'h000 || st_nxt.ch[i].held) begin
                busy = 1'b1;
            end
        end

        // all phase work finished alarm
        st_nxt.done = !busy && st_nxt.fsm == DCP_IDLE && !st_nxt.pend_sync
                      && !st_nxt.pend_pulse;
    end

    // state register, restart acts as reset
    always_ff @(posedge sys_clk) begin
        if (!rstn || soft_restart) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    always_comb begin
        for (int i = 0; i < DCP_NCH; i++) begin
            chan_out[i]   = st_r.ch[i].out;
            buf_en[i]     = st_r.ch[i].buf_en;
            idle_float[i] = st_r.ch[i].idle_float;
        end
        phase_done = st_r.done;
    end

endmodule : dcp_channel_ctrl
`default_nettype wire

// [dcp_host_model.sv]
// host-side trigger model: turns one-cycle commands into pin edges
// assumes sys_clk is shared with the block and commands are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module dcp_host_model (
    input  wire logic sys_clk,
    input  wire logic pin_go,
    input  wire logic mcr_go,
    output logic      general_input_pin,
    output logic      multi_chip_realign
);
    logic [1:0] pin_r = 2'h0;
    logic [1:0] mcr_r = 2'h0;
    // each command becomes a two-cycle high level, so the block sees one clean rise
    always_ff @(posedge sys_clk) begin
        pin_r <= {pin_r[0], pin_go};
        mcr_r <= {mcr_r[0], mcr_go};
    end
    assign general_input_pin  = |pin_r;
    assign multi_chip_realign = |mcr_r;
endmodule : dcp_host_model
`default_nettype wire

// [dcp_assertions.sv]
// checker for the channel controller ports
// assumes one sys_clk domain; channels 1, 3 dynamic and 4 disabled by the bench
`timescale 1ns/10ps
`default_nettype none
module dcp_assertions
    import dcp_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire logic               soft_restart,
    input wire logic               spi_slip_req,
    input wire logic               spi_sync_req,
    input wire logic               spi_pulse_req,
    input wire dcp_cfg_s           chan_cfg [DCP_NCH],
    input wire logic [DCP_NCH-1:0] chan_out,
    input wire logic [DCP_NCH-1:0] buf_en,
    input wire logic [DCP_NCH-1:0] idle_float,
    input wire logic               phase_done
);
    localparam int DONE_MAX = 300;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn || soft_restart);
    // sequencer quiet for three cycles, and a sequencing request
    sequence s_idle3; phase_done [*3]; endsequence
    sequence s_req; spi_sync_req || spi_pulse_req; endsequence
    a_reset_clears: assert property (disable iff (1'b0) !rstn |=> chan_out == '0 && !phase_done)
        else $error("outputs not cleared by reset");
    a_req_busy: assert property (s_req |=> !phase_done)
        else $error("sequencing request left done high");
    a_slip_busy: assert property (spi_slip_req && chan_cfg[2].enable && chan_cfg[2].slip_accept |=> !phase_done)
        else $error("slip left done high");
    a_done_returns: assert property ($fell(phase_done) |-> ##[1:DONE_MAX] phase_done)
        else $error("phase work never finished");
    a_disabled_dark: assert property ((!chan_cfg[4].enable) [*2] |-> !buf_en[4] && !chan_out[4])
        else $error("disabled channel active");
    a_dyn_quiet: assert property ((chan_cfg[1].launch == DCP_DYNAMIC) throughout s_idle3 |-> !chan_out[1])
        else $error("dynamic channel toggles outside train");
    a_buf_follow: assert property (chan_cfg[1].buf_follow throughout s_idle3 |-> !buf_en[1])
        else $error("buffer on between trains");
    a_buf_enable: assert property ((chan_cfg[3].enable && !chan_cfg[3].buf_follow) [*3] |-> buf_en[3])
        else $error("buffer not tracking enable");
    a_idle_float: assert property ((chan_cfg[3].enable && !chan_cfg[3].idle_low) throughout s_idle3
        |-> idle_float[3] && !chan_out[3])
        else $error("idle output not floating");
endmodule : dcp_assertions
bind dcp_channel_ctrl dcp_assertions chk_u (.sys_clk(sys_clk), .rstn(rstn), .soft_restart(soft_restart),
    .spi_slip_req(spi_slip_req), .spi_sync_req(spi_sync_req), .spi_pulse_req(spi_pulse_req),
    .chan_cfg(chan_cfg), .chan_out(chan_out), .buf_en(buf_en), .idle_float(idle_float), .phase_done(phase_done));
`default_nettype wire

// [dcp_channel_ctrl_test.sv]
// bench for the channel controller: realign, slips and pulse trains
// assumes the host model supplies pin and multi-chip realign edges
`timescale 1ns/10ps
`default_nettype none
module dcp_channel_ctrl_test
    import dcp_pkg::*;
;
    logic               sys_clk = 0, rstn = 0, soft_restart = 0, pin_go = 0, mcr_go = 0;
    logic               spi_slip_req = 0, spi_sync_req = 0, spi_pulse_req = 0, phase_done;
    logic               general_input_pin, multi_chip_realign;
    logic [1:0]         pin_function = DCP_PIN_NONE;
    logic [11:0]        ref_cnt = 12'h008;
    logic [7:0]         n_per = 8'h04;
    logic [DCP_NCH-1:0] chan_out, buf_en, idle_float;
    logic [DCP_NCH-1:0] prev_r = '0;
    dcp_cfg_s           cfg [DCP_NCH];
    int                 cyc = 0, fail_count = 0, samples_checked = 0;
    int                 rise_t [DCP_NCH] = '{default: 0};
    int                 rise_n [DCP_NCH] = '{default: 0};
    dcp_host_model host_u (.sys_clk(sys_clk), .pin_go(pin_go), .mcr_go(mcr_go),
        .general_input_pin(general_input_pin), .multi_chip_realign(multi_chip_realign));
    dcp_channel_ctrl dut_u (.sys_clk(sys_clk), .rstn(rstn), .soft_restart(soft_restart),
        .spi_slip_req(spi_slip_req), .spi_sync_req(spi_sync_req), .spi_pulse_req(spi_pulse_req),
        .general_input_pin(general_input_pin), .pin_function(pin_function),
        .multi_chip_realign(multi_chip_realign), .reference_period_count(ref_cnt), .pulse_periods(n_per),
        .chan_cfg(cfg), .chan_out(chan_out), .buf_en(buf_en), .idle_float(idle_float), .phase_done(phase_done));
    // 200 MHz clock
    initial forever #2.5 sys_clk = ~sys_clk;
    // rising edges of every channel, by cycle
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        prev_r <= chan_out;
        for (int k = 0; k < DCP_NCH; k++) if (chan_out[k] && !prev_r[k]) begin
            rise_t[k] <= cyc;
            rise_n[k] <= rise_n[k] + 1;
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // one request (0 slip, 1 realign, 2 pulse, 3 pin, 4 multi-chip), then wait for done
    task automatic fire(input int k);
        @(posedge sys_clk);
        {mcr_go, pin_go, spi_pulse_req, spi_sync_req, spi_slip_req} <= 5'h01 << k;
        @(posedge sys_clk);
        {mcr_go, pin_go, spi_pulse_req, spi_sync_req, spi_slip_req} <= 5'h00;
        tick(4);
        for (int i = 0; i < 400 && phase_done !== 1'b1; i++) @(posedge sys_clk);
        chk("phase_done", phase_done, 16'h0001);
        tick(100);
    endtask : fire
    // phase lag of channel k behind channel 0, divide 40
    function automatic logic [15:0] lag(input int k);
        return 16'((rise_t[k] - rise_t[0] + 400) % 40);
    endfunction : lag
    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        int n1;
        int n3;
        for (int k = 0; k < DCP_NCH; k++) cfg[k] = '0;
        cfg[0] = '{1, 0, 1, DCP_ASYNC, 0, 0, 0, 12'h000, 12'h028};
        cfg[2] = '{1, 1, 1, DCP_ASYNC, 0, 0, 1, 12'h005, 12'h028};
        cfg[5] = '{1, 1, 1, DCP_ASYNC, 0, 0, 0, 12'h000, 12'h028};
        cfg[4] = '{0, 1, 1, DCP_ASYNC, 0, 0, 0, 12'h000, 12'h028};
        cfg[1] = '{1, 0, 1, DCP_DYNAMIC, 1, 1, 0, 12'h000, 12'h028};
        cfg[3] = '{1, 0, 1, DCP_DYNAMIC, 0, 0, 0, 12'h000, 12'h028};
        tick(4);
        rstn <= 1'b1;
        tick(2);
        fire(1);
        chk("lag2", lag(2), 16'h0005);
        chk("lag5", lag(5), 16'h0000);
        chk("buf4", buf_en[4], 16'h0000);
        $display("test 1 done");
        fire(0);
        chk("lag2", lag(2), 16'h000a);
        chk("lag5", lag(5), 16'h0001);
        cfg[2].realign_accept <= 1'b0;
        tick(7);
        cfg[2].realign_accept <= 1'b1;
        tick(100);
        chk("lag2", lag(2), 16'h000a);
        $display("test 2 done");
        pin_function <= DCP_PIN_SLIP;
        fire(3);
        chk("lag2", lag(2), 16'h000f);
        chk("lag5", lag(5), 16'h0002);
        fire(4);
        chk("lag2", lag(2), 16'h0005);
        chk("lag5", lag(5), 16'h0000);
        $display("test 3 done");
        n1 = rise_n[1];
        fire(2);
        chk("rises1", 16'(rise_n[1] - n1), 16'h0001);
        chk("buf1", buf_en[1], 16'h0000);
        pin_function <= DCP_PIN_PULSE;
        n3 = rise_n[3];
        fire(3);
        chk("rises3", 16'(rise_n[3] - n3), 16'h0001);
        chk("buf3", buf_en[3], 16'h0001);
        chk("float3", idle_float[3], 16'h0001);
        chk("out1", chan_out[1], 16'h0000);
        $display("test 4 done");
        // mid-run restart: outputs dark at first edge, settled at the second
        soft_restart <= 1'b1;
        tick(2);
        soft_restart <= 1'b0;
        tick(1);
        chk("done_rst", phase_done, 16'h0000);
        chk("out_rst", chan_out, 16'h0000);
        tick(1);
        chk("done_up", phase_done, 16'h0001);
        chk("buf0", buf_en[0], 16'h0001);
        $display("test 5 done");
        close_out;
    end
    // watchdog against a hung sequence
    initial begin
        tick(5000);
        fail_count++;
        close_out;
    end
endmodule : dcp_channel_ctrl_test
`default_nettype wire
